// ### dacp_defines.vh
`ifndef DACP_DEFINES_VH
`define DACP_DEFINES_VH

// Clock rate of clk_sys
`define DACP_CLK_HZ 10000000

// Zero-crossing window, in ms
`define DACP_ZC_WINDOW_MS 50
// Nonvolatile programming time, in ms (plain default)
`define DACP_NV_WRITE_MS 10

// Slave address upper nibble
`define DACP_ADDR_HI 4'h5

// Command byte top bits
`define DACP_CMD_WIPER0 2'h0
`define DACP_CMD_WIPER1 2'h1
`define DACP_CMD_SETUP 2'h2
`define DACP_CMD_RSVD 2'h3

// Setup byte layout and reset value
`define DACP_SETUP_RESET 8'h87
`define DACP_SETUP_TAPER 0
`define DACP_SETUP_ZC 1
`define DACP_SETUP_STORE 2

// Mute codes per taper
`define DACP_MUTE_63 6'h3F
`define DACP_MUTE_33 6'h21

// Serial state codes
`define DACP_S_IDLE 3'h0
`define DACP_S_RX 3'h1
`define DACP_S_ACK 3'h2
`define DACP_S_TX 3'h3
`define DACP_S_RACK 3'h4

`endif

// ### dacp_core.v
// Summary of operation
// - Command top bits 00 set wiper 0, 01 set wiper 1, 10 set configuration.
// - Command top bits 11 are reserved; the device acknowledges them but changes nothing.
// - A wiper command takes the low six bits as the new position.
// - Configuration written only for bits 7:6 = 10, kept in nonvolatile storage.
// - Configuration bits 5, 4 and 3 have no effect.
// - Bit 0 picks taper for both channels: 0 is 63+mute, 1 is 33+mute.
// - Bit 1 enables zero-crossing gating of wiper changes; default on.
// - Bit 2: 0 keeps wipers nonvolatile, 1 volatile; default volatile.
// - With volatile storage both wipers start at mute after power-up.
// - While enable pin is high, serial clock and data are ignored.
// - Only a first byte after START with upper nibble 0101 is answered.
// - Low three address bits are compared to the three strap pins.
// - Address LSB picks direction: 1 read, 0 write.
// - In a write, the byte after the address is a command byte.
// - A matching address byte is acknowledged.
// - A read returns wiper 0, wiper 1, then configuration, eight bits each.
// - If master acknowledges configuration byte, the three-byte cycle repeats.
// - In nonvolatile mode programming starts only on the STOP ending a write.
// - In volatile mode a STOP after a write starts no programming.
// - Gated wipers change at zero crossing, or when the 50 ms window ends.
// - Ungated wipers take the new position as soon as the command is acked.
// - With gating on, programming waits until pending zero-cross waits finish.
// - During programming the slave address is not acknowledged.
`timescale 1ns/1ps
`include "dacp_defines.vh"

module dacp_core #(
    parameter ZC_WINDOW_CYC = `DACP_ZC_WINDOW_MS * (`DACP_CLK_HZ / 1000),
    parameter NV_WRITE_CYC = `DACP_NV_WRITE_MS * (`DACP_CLK_HZ / 1000)
) (
    input wire clk_sys,
    input wire arst_n,
    input wire scl,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    input wire enable_n,
    input wire strap_addr_bit0,
    input wire strap_addr_bit1,
    input wire strap_addr_bit2,
    input wire zero_cross0,
    input wire zero_cross1,
    output wire [5:0] wiper0_pos,
    output wire [5:0] wiper1_pos,
    output reg taper_sel,
    output reg zc_enable,
    output reg storage_select,
    output reg nv_busy
);

    // Two-flop synchronisers for everything from the pins
    reg [1:0] scl_s;
    reg [1:0] sda_s;
    reg [1:0] en_s;
    reg [1:0] zc0_s;
    reg [1:0] zc1_s;
    reg [2:0] strap_s1;
    reg [2:0] strap_s2;
    reg scl_d;
    reg sda_d;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            en_s <= 2'h3;
            zc0_s <= 2'h0;
            zc1_s <= 2'h0;
            strap_s1 <= 3'h0;
            strap_s2 <= 3'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl};
            sda_s <= {sda_s[0], sda_in};
            en_s <= {en_s[0], enable_n};
            zc0_s <= {zc0_s[0], zero_cross0};
            zc1_s <= {zc1_s[0], zero_cross1};
            strap_s1 <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
            strap_s2 <= strap_s1;
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end

    wire bus_on = ~en_s[1];
    wire scl_rise = bus_on & scl_s[1] & ~scl_d;
    wire scl_fall = bus_on & ~scl_s[1] & scl_d;
    // Bus conditions only count while enabled
    wire start_det = bus_on & scl_s[1] & scl_d & sda_d & ~sda_s[1];
    wire stop_det = bus_on & scl_s[1] & scl_d & ~sda_d & sda_s[1];

    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] txreg;
    reg [1:0] rd_idx;
    reg is_addr;
    reg rw;
    reg mst_ack;
    reg wrote_any;
    reg [7:0] setup_byte;
    reg [5:0] target0;
    reg [5:0] target1;
    reg [1:0] wr_pulse;
    reg nv_req;
    reg [19:0] nv_cnt;
    wire [1:0] zc_pend;

    wire addr_match = (shreg[7:4] == `DACP_ADDR_HI)
        && (shreg[3:1] == strap_s2);

    // Read-back byte for a given slot of the three-byte cycle
    function [7:0] rd_byte;
        input [1:0] idx;
        input [5:0] t0;
        input [5:0] t1;
        input [7:0] cfg;
        begin
            case (idx)
                2'h0: rd_byte = {`DACP_CMD_WIPER0, t0};
                2'h1: rd_byte = {`DACP_CMD_WIPER1, t1};
                default: rd_byte = cfg;
            endcase
        end
    endfunction
    wire [1:0] next_idx = (state == `DACP_S_ACK || rd_idx == 2'h2) ? 2'h0 : rd_idx + 2'h1;
    wire [7:0] next_byte = rd_byte(next_idx, target0, target1, setup_byte);

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= `DACP_S_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            rd_idx <= 2'h0;
            is_addr <= 1'b0;
            rw <= 1'b0;
            mst_ack <= 1'b0;
            wrote_any <= 1'b0;
            setup_byte <= `DACP_SETUP_RESET;
            target0 <= `DACP_MUTE_63;
            target1 <= `DACP_MUTE_63;
            wr_pulse <= 2'h0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            wr_pulse <= 2'h0;
            sda_out <= 1'b0;
            if (!bus_on) begin
                // Disabled: drop any transfer and let go of the data line
                state <= `DACP_S_IDLE;
                sda_oe <= 1'b0;
            end else if (start_det) begin
                state <= `DACP_S_RX;
                bitcnt <= 4'h0;
                is_addr <= 1'b1;
                wrote_any <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_det) begin
                state <= `DACP_S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    `DACP_S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    `DACP_S_RX: begin
                        if (scl_rise && bitcnt != 4'h8) begin
                            shreg <= {shreg[6:0], sda_s[1]};
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == 4'h8) begin
                            if (is_addr) begin
                                // No answer while programming, so the master can poll
                                if (addr_match && !nv_busy && !nv_req) begin
                                    sda_oe <= 1'b1;
                                    rw <= shreg[0];
                                    state <= `DACP_S_ACK;
                                end else begin
                                    state <= `DACP_S_IDLE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                state <= `DACP_S_ACK;
                                case (shreg[7:6])
                                    `DACP_CMD_WIPER0: begin
                                        target0 <= shreg[5:0];
                                        wr_pulse <= 2'h1;
                                        wrote_any <= 1'b1;
                                    end
                                    `DACP_CMD_WIPER1: begin
                                        target1 <= shreg[5:0];
                                        wr_pulse <= 2'h2;
                                        wrote_any <= 1'b1;
                                    end
                                    `DACP_CMD_SETUP: begin
                                        setup_byte <= shreg;
                                        wrote_any <= 1'b1;
                                    end
                                    default: begin
                                        // Reserved command leaves everything alone
                                        wrote_any <= wrote_any;
                                    end
                                endcase
                            end
                        end
                    end
                    `DACP_S_ACK: begin
                        if (scl_fall) begin
                            if (is_addr && rw) begin
                                rd_idx <= 2'h0;
                                txreg <= {next_byte[6:0], 1'b0};
                                sda_oe <= ~next_byte[7];
                                bitcnt <= 4'h1;
                                state <= `DACP_S_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                bitcnt <= 4'h0;
                                state <= `DACP_S_RX;
                            end
                            is_addr <= 1'b0;
                        end
                    end
                    `DACP_S_TX: begin
                        if (scl_fall) begin
                            if (bitcnt == 4'h8) begin
                                sda_oe <= 1'b0;
                                state <= `DACP_S_RACK;
                            end else begin
                                sda_oe <= ~txreg[7];
                                txreg <= {txreg[6:0], 1'b0};
                                bitcnt <= bitcnt + 4'h1;
                            end
                        end
                    end
                    `DACP_S_RACK: begin
                        if (scl_rise) begin
                            mst_ack <= ~sda_s[1];
                        end else if (scl_fall) begin
                            if (mst_ack) begin
                                // Wrap after the configuration byte
                                rd_idx <= next_idx;
                                txreg <= {next_byte[6:0], 1'b0};
                                sda_oe <= ~next_byte[7];
                                bitcnt <= 4'h1;
                                state <= `DACP_S_TX;
                            end else begin
                                state <= `DACP_S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state <= `DACP_S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Per-channel zero-crossing gating and applied position
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : ch_g
            wire zc_hit = (ch == 0) ? zc0_s[1] : zc1_s[1];
            wire [5:0] tgt = (ch == 0) ? target0 : target1;
            reg pend;
            reg [19:0] tmr;
            reg [5:0] applied;
            reg [5:0] pos_q;
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    pend <= 1'b0;
                    tmr <= 20'h00000;
                    applied <= `DACP_MUTE_63;
                    pos_q <= `DACP_MUTE_63;
                end else begin
                    if (wr_pulse[ch]) begin
                        if (setup_byte[`DACP_SETUP_ZC]) begin
                            pend <= 1'b1;
                            tmr <= 20'h00000;
                        end else begin
                            applied <= tgt;
                            pend <= 1'b0;
                        end
                    end else if (pend) begin
                        // Window end forces the change even without a crossing
                        if (zc_hit || tmr == ZC_WINDOW_CYC - 1) begin
                            applied <= tgt;
                            pend <= 1'b0;
                        end else begin
                            tmr <= tmr + 20'h00001;
                        end
                    end
                    // Taper bit shared by both channels; only bits 2:0 matter
                    if (setup_byte[`DACP_SETUP_TAPER] && applied > `DACP_MUTE_33)
                        pos_q <= `DACP_MUTE_33;
                    else
                        pos_q <= applied;
                end
            end
            assign zc_pend[ch] = pend;
        end
    endgenerate

    assign wiper0_pos = ch_g[0].pos_q;
    assign wiper1_pos = ch_g[1].pos_q;

    // Nonvolatile programming sequencer
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_req <= 1'b0;
            nv_busy <= 1'b0;
            nv_cnt <= 20'h00000;
            taper_sel <= 1'b1;
            zc_enable <= 1'b1;
            storage_select <= 1'b1;
        end else begin
            taper_sel <= setup_byte[`DACP_SETUP_TAPER];
            zc_enable <= setup_byte[`DACP_SETUP_ZC];
            storage_select <= setup_byte[`DACP_SETUP_STORE];
            if (stop_det && wrote_any && !setup_byte[`DACP_SETUP_STORE] && state != `DACP_S_IDLE)
                nv_req <= 1'b1;
            else if (nv_req && zc_pend == 2'h0 && !nv_busy) begin
                nv_req <= 1'b0;
                nv_busy <= 1'b1;
                nv_cnt <= 20'h00000;
            end else if (nv_busy) begin
                if (nv_cnt == NV_WRITE_CYC - 1)
                    nv_busy <= 1'b0;
                else
                    nv_cnt <= nv_cnt + 20'h00001;
            end
        end
    end

endmodule

// ### dacp_core_props.sv
`timescale 1ns/1ps
module dacp_core_props #(
    parameter NV_WRITE_CYC = 100
) (
    input wire clk_sys,
    input wire arst_n,
    input wire scl,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire enable_n,
    input wire strap_addr_bit0,
    input wire strap_addr_bit1,
    input wire strap_addr_bit2,
    input wire zero_cross0,
    input wire zero_cross1,
    input wire [5:0] wiper0_pos,
    input wire [5:0] wiper1_pos,
    input wire taper_sel,
    input wire zc_enable,
    input wire storage_select,
    input wire nv_busy
);
    integer nv_cnt;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    // Length of the current busy run
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            nv_cnt <= 0;
        else if (nv_busy)
            nv_cnt <= nv_cnt + 1;
        else
            nv_cnt <= 0;
    end
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("sda_out driven high");
    a_oe_at_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("sda drive changed while scl high");
    a_ack_stands: assert property ($rose(sda_oe) |-> sda_oe [*7])
        else $error("driven bit too short");
    a_enable_quiet: assert property (enable_n [*6] |-> !sda_oe)
        else $error("sda driven while disabled");
    a_busy_no_ack: assert property (nv_busy |-> !sda_oe)
        else $error("acknowledge during programming");
    a_nv_length: assert property ($fell(nv_busy) |-> nv_cnt == NV_WRITE_CYC)
        else $error("programming length wrong");
    a_nv_only_nonvol: assert property ($rose(nv_busy) |-> !storage_select)
        else $error("programming in volatile mode");
    a_taper_clamp: assert property (taper_sel && $past(taper_sel) && $past(arst_n)
        |-> wiper0_pos <= 6'h21 && wiper1_pos <= 6'h21)
        else $error("position above mute in short taper");
    a_reset_setup: assert property ($rose(arst_n)
        |-> taper_sel && zc_enable && storage_select && !nv_busy)
        else $error("setup outputs wrong after reset");
endmodule
bind dacp_core dacp_core_props #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_dacp_core_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .enable_n(enable_n), .strap_addr_bit0(strap_addr_bit0),
    .strap_addr_bit1(strap_addr_bit1), .strap_addr_bit2(strap_addr_bit2),
    .zero_cross0(zero_cross0), .zero_cross1(zero_cross1), .wiper0_pos(wiper0_pos),
    .wiper1_pos(wiper1_pos), .taper_sel(taper_sel), .zc_enable(zc_enable),
    .storage_select(storage_select), .nv_busy(nv_busy));

// ### dacp_mst.sv
`timescale 1ns/1ps
module dacp_mst (
    input wire clk_sys,
    input wire sda,
    output reg scl,
    output reg sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    // Quarter of an 800 ns bit
    task qtr;
        repeat (2) @(posedge clk_sys);
    endtask
    task start;
        begin
            sda_oe <= 1'b0;
            qtr;
            scl <= 1'b1;
            qtr;
            sda_oe <= 1'b1;
            qtr;
            scl <= 1'b0;
            qtr;
        end
    endtask
    // Data only moves while scl is low
    task xbit(input b, output r);
        begin
            sda_oe <= ~b;
            qtr;
            scl <= 1'b1;
            qtr;
            r = sda;
            qtr;
            scl <= 1'b0;
            qtr;
        end
    endtask
    task xbyte(input [7:0] d, input ab, output [7:0] q, output ar);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1)
                xbit(d[i], q[i]);
            xbit(ab, ar);
        end
    endtask
    task stop;
        begin
            sda_oe <= 1'b1;
            qtr;
            scl <= 1'b1;
            qtr;
            sda_oe <= 1'b0;
            qtr;
        end
    endtask
endmodule

// ### tb_dacp_core.sv
`timescale 1ns/1ps
module tb_dacp_core;
    reg clk_sys, arst_n, enable_n, zc0, zc1, ar;
    reg [2:0] strap;
    reg [6:0] a;
    reg [7:0] q;
    reg [15:0] lfsr;
    wire scl, m_oe, sda_out, sda_oe, taper_sel, zc_enable, storage_select, nv_busy;
    wire [5:0] pos0, pos1;
    wire sda = ~(m_oe | sda_oe);
    integer num_errors, n_tests, m_w0, m_w1, m_cfg, i, o0, o1;
    dacp_core #(.ZC_WINDOW_CYC(200), .NV_WRITE_CYC(100)) u_dacp_core (
        .clk_sys(clk_sys), .arst_n(arst_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .enable_n(enable_n), .strap_addr_bit0(strap[0]),
        .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]), .zero_cross0(zc0),
        .zero_cross1(zc1), .wiper0_pos(pos0), .wiper1_pos(pos1), .taper_sel(taper_sel),
        .zc_enable(zc_enable), .storage_select(storage_select), .nv_busy(nv_busy));
    dacp_mst u_dacp_mst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_oe(m_oe));
    function [15:0] nxt(input [15:0] s);
        nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function [7:0] ep(input integer w);
        ep = (m_cfg[0] && w > 33) ? 8'h21 : w[7:0];
    endfunction
    task check(input [8*12:1] nm, input [7:0] seen, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("errors %0d of %0d checks", num_errors, n_tests);
            if (num_errors == 0 && n_tests > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task chk_out;
        begin
            check("pos0", pos0, ep(m_w0));
            check("pos1", pos1, ep(m_w1));
            check("taper", taper_sel, m_cfg[0]);
            check("zc_en", zc_enable, m_cfg[1]);
            check("store", storage_select, m_cfg[2]);
        end
    endtask
    task adr(input [6:0] ad, input rw);
        begin
            u_dacp_mst.start;
            u_dacp_mst.xbyte({ad, rw}, 1'b1, q, ar);
        end
    endtask
    task cmd(input [7:0] c);
        begin
            u_dacp_mst.xbyte(c, 1'b1, q, ar);
            check("cmd_ack", ar, 0);
            case (c[7:6])
                2'h0: m_w0 = c[5:0];
                2'h1: m_w1 = c[5:0];
                2'h2: m_cfg = c;
                default: ;
            endcase
            repeat (6) @(posedge clk_sys);
        end
    endtask
    task wait_nv(input v, input integer lim);
        integer k;
        begin
            k = 0;
            while (nv_busy !== v && k < lim) begin
                @(posedge clk_sys);
                k = k + 1;
            end
            check("nv_busy", nv_busy, v);
        end
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // Whole run needs roughly 3100 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors = num_errors + 1;
        summarize;
    end
    initial begin
        arst_n = 1'b0;
        enable_n = 1'b0;
        zc0 = 1'b0;
        zc1 = 1'b0;
        strap = 3'h0;
        num_errors = 0;
        n_tests = 0;
        lfsr = 16'h97DF;
        m_w0 = 63;
        m_w1 = 63;
        m_cfg = 8'h87;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        strap <= lfsr[2:0];
        repeat (6) @(posedge clk_sys);
        chk_out;
        adr({4'h5, strap}, 1'b0);
        check("adr_ack", ar, 0);
        cmd(8'hBC);
        for (i = 0; i < 8; i = i + 1) begin
            lfsr = nxt(lfsr);
            cmd({lfsr[8] & lfsr[9], lfsr[9], lfsr[5:0]});
            chk_out;
        end
        cmd(8'h2A);
        cmd(8'hC0);
        chk_out;
        cmd(8'h85);
        u_dacp_mst.stop;
        adr({4'h5, strap}, 1'b1);
        check("rd_ack", ar, 0);
        for (i = 0; i < 5; i = i + 1) begin
            u_dacp_mst.xbyte(8'hFF, i == 4, q, ar);
            check("rd_byte", q, i % 3 == 0 ? m_w0 : i % 3 == 1 ? 64 + m_w1 : m_cfg);
        end
        u_dacp_mst.stop;
        // Wrong nibble, two strap mismatches, then a disabled bus
        for (i = 0; i < 4; i = i + 1) begin
            a = {4'h5, strap};
            if (i == 0)
                a[6:3] = 4'h4;
            else if (i < 3)
                a = a ^ i[2:0];
            enable_n <= (i == 3);
            repeat (4) @(posedge clk_sys);
            adr(a, 1'b0);
            check("nack", ar, 1);
            u_dacp_mst.xbyte(8'h01, 1'b1, q, ar);
            u_dacp_mst.stop;
            chk_out;
        end
        enable_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        adr({4'h5, strap}, 1'b0);
        cmd(8'hBA);
        u_dacp_mst.stop;
        wait_nv(1, 50);
        adr({4'h5, strap}, 1'b0);
        check("busy_nack", ar, 1);
        u_dacp_mst.stop;
        wait_nv(0, 150);
        o0 = m_w0;
        o1 = m_w1;
        adr({4'h5, strap}, 1'b0);
        cmd(8'h05);
        cmd(8'h47);
        u_dacp_mst.stop;
        repeat (10) @(posedge clk_sys);
        check("zc_hold0", pos0, ep(o0));
        check("nv_wait", nv_busy, 0);
        zc0 <= 1'b1;
        repeat (6) @(posedge clk_sys);
        zc0 <= 1'b0;
        check("zc_pos0", pos0, ep(m_w0));
        check("zc_hold1", pos1, ep(o1));
        wait_nv(1, 250);
        chk_out;
        wait_nv(0, 150);
        adr({4'h5, strap}, 1'b0);
        cmd(8'h87);
        u_dacp_mst.stop;
        repeat (20) @(posedge clk_sys);
        check("vol_nv", nv_busy, 0);
        chk_out;
        summarize;
    end
endmodule
